//--- sct_timer.sv
// Purpose: Single channel 16-bit timer with APB registers.
// Assumes: APB slave, zero wait after the setup cycle, pclk 50 MHz.
// Notes: Output reference is high while count is below active compare.
`timescale 1ns/1ps
`default_nettype none
module sct_timer (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic chan_pin_in,
  input wire logic divided_oscillator_clock,
  output logic chan_output,
  output logic output_drive_enable
);
  import sct_pkg::*;

  // ----------------------------------------
  // Register state
  // ----------------------------------------
  logic [15:0] enpol_ff;
  logic [15:0] mode_ff;
  logic [15:0] count_value_ff;
  logic [15:0] divider_value_ff;
  logic [15:0] reload_value_ff;
  logic [15:0] compare_capture_ff;
  logic [15:0] active_compare_ff;
  logic [15:0] route_ff;
  logic [31:0] prdata_ff;
  logic pready_ff;
  logic pslverr_ff;
  logic chan_output_ff;
  logic output_drive_enable_ff;
  sct_apb_t apb_state_ff;

  logic setup_phase;
  logic wr_en;
  logic addr_ok;
  logic [15:0] rd_mux;
  logic counter_tick;
  logic update_event;
  logic capture;
  logic filtered_chan_input;
  logic chan_enable;
  logic chan_polarity;
  logic chan_comp_polarity;
  logic compare_preload_enable;
  logic [1:0] chan_direction;
  logic [1:0] capture_event_divider;
  logic [1:0] input_route_select;
  logic is_out;
  logic is_in;
  logic output_reference;
  logic [15:0] wdata16;

  assign chan_enable = enpol_ff[SCT_EN_BIT];
  assign chan_polarity = enpol_ff[SCT_POL_BIT];
  assign chan_comp_polarity = enpol_ff[SCT_NPOL_BIT];
  assign chan_direction = mode_ff[SCT_DIR_LSB +: 2];
  assign capture_event_divider = mode_ff[SCT_EVDIV_LSB +: 2];
  assign compare_preload_enable = mode_ff[SCT_PRELOAD_BIT];
  assign input_route_select = route_ff[1:0];
  assign is_out = (chan_direction == SCT_DIR_OUT);
  assign is_in = (chan_direction == SCT_DIR_IN);
  assign wdata16 = pwdata[15:0];

  // ----------------------------------------
  // APB slave
  // ----------------------------------------
  assign setup_phase = psel & ~penable;
  assign wr_en = psel & penable & pready_ff & pwrite & ~pslverr_ff;

  always_comb
  begin
    addr_ok = 1'b1;
    rd_mux = 16'h0000;
    case (paddr)
      SCT_OFF_MODE: rd_mux = mode_ff;
      SCT_OFF_ENPOL: rd_mux = enpol_ff;
      SCT_OFF_COUNT: rd_mux = count_value_ff;
      SCT_OFF_DIV: rd_mux = divider_value_ff;
      SCT_OFF_RELOAD: rd_mux = reload_value_ff;
      SCT_OFF_CCV: rd_mux = compare_capture_ff;
      SCT_OFF_ROUTE: rd_mux = route_ff;
      default: addr_ok = 1'b0;
    endcase
  end

  // Answer registered in the setup cycle, so access lasts one cycle
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      apb_state_ff <= SCT_APB_IDLE;
    else if (setup_phase)
      apb_state_ff <= SCT_APB_ACCESS;
    else
      apb_state_ff <= SCT_APB_IDLE;
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      pready_ff <= 1'b0;
      pslverr_ff <= 1'b0;
      prdata_ff <= 32'h0000_0000;
    end
    else
    begin
      pready_ff <= setup_phase;
      pslverr_ff <= setup_phase & ~addr_ok;
      if (setup_phase && !pwrite)
        prdata_ff <= {16'h0000, rd_mux};
    end
  end

  assign prdata = prdata_ff;
  assign pready = pready_ff;
  assign pslverr = pslverr_ff;

  // ----------------------------------------
  // Control registers
  // ----------------------------------------
  // Reserved bits are masked so they always read back zero
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      enpol_ff <= SCT_RST16;
    else if (wr_en && paddr == SCT_OFF_ENPOL)
      enpol_ff <= wdata16 & SCT_ENPOL_MASK;
  end

  // Direction may only change while the channel is off
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      mode_ff <= SCT_RST16;
    else if (wr_en && paddr == SCT_OFF_MODE)
    begin
      mode_ff[15:2] <= wdata16[15:2] & SCT_MODE_MASK[15:2];
      if (!chan_enable)
        mode_ff[1:0] <= wdata16[1:0];
    end
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      route_ff <= SCT_RST16;
    else if (wr_en && paddr == SCT_OFF_ROUTE)
      route_ff <= wdata16 & SCT_ROUTE_MASK;
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      divider_value_ff <= SCT_RST16;
    else if (wr_en && paddr == SCT_OFF_DIV)
      divider_value_ff <= wdata16;
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      reload_value_ff <= SCT_RST16;
    else if (wr_en && paddr == SCT_OFF_RELOAD)
      reload_value_ff <= wdata16;
  end

  // ----------------------------------------
  // Time base
  // ----------------------------------------
  sct_prescaler #(
    .DW(SCT_DW)
  ) u_prescaler (
    .pclk(pclk),
    .presetn(presetn),
    .div_value(divider_value_ff),
    .update(update_event),
    .tick(counter_tick)
  );

  // Reload of zero stops counting and so also stops update events
  assign update_event = counter_tick & (reload_value_ff != 16'h0000)
    & (count_value_ff >= reload_value_ff);

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      count_value_ff <= SCT_RST16;
    else if (wr_en && paddr == SCT_OFF_COUNT)
      count_value_ff <= wdata16;
    else if (reload_value_ff == 16'h0000)
      count_value_ff <= count_value_ff;
    else if (update_event)
      count_value_ff <= 16'h0000;
    else if (counter_tick)
      count_value_ff <= count_value_ff + 16'h0001;
  end

  // ----------------------------------------
  // Channel
  // ----------------------------------------
  assign filtered_chan_input = (input_route_select == SCT_ROUTE_OSC)
    ? divided_oscillator_clock : chan_pin_in;

  sct_capture u_capture (
    .pclk(pclk),
    .presetn(presetn),
    .filtered_chan_input(filtered_chan_input),
    .edge_sel({chan_comp_polarity, chan_polarity}),
    .capture_event_divider(capture_event_divider),
    .chan_enable(chan_enable),
    .capture(capture)
  );

  // Capture beats a software write in the same cycle
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      compare_capture_ff <= SCT_RST16;
    else if (is_in && capture)
      compare_capture_ff <= count_value_ff;
    else if (wr_en && paddr == SCT_OFF_CCV)
      compare_capture_ff <= wdata16;
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      active_compare_ff <= SCT_RST16;
    else if (!compare_preload_enable && wr_en && paddr == SCT_OFF_CCV)
      active_compare_ff <= wdata16;
    else if (compare_preload_enable && update_event)
      active_compare_ff <= compare_capture_ff;
  end

  assign output_reference = (count_value_ff < active_compare_ff);

  // Polarity ignores the complementary bit, software keeps it clear here
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      chan_output_ff <= 1'b0;
      output_drive_enable_ff <= 1'b0;
    end
    else if (is_out && chan_enable)
    begin
      chan_output_ff <= output_reference ^ chan_polarity;
      output_drive_enable_ff <= 1'b1;
    end
    else
    begin
      chan_output_ff <= 1'b0;
      output_drive_enable_ff <= 1'b0;
    end
  end

  assign chan_output = chan_output_ff;
  assign output_drive_enable = output_drive_enable_ff;

  // ----------------------------------------
  // Assertions
  // ----------------------------------------
  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);

  property p_out_off;
    !(is_out && chan_enable) |=> !chan_output && !output_drive_enable;
  endproperty
  a_out_off: assert property (p_out_off) else $error("disabled output not low");

  property p_out_pol;
    (is_out && chan_enable) |=> output_drive_enable
      && chan_output == ($past(output_reference) ^ $past(chan_polarity));
  endproperty
  a_out_pol: assert property (p_out_pol) else $error("output level wrong");

  property p_cap_gate;
    (!chan_enable && !(wr_en && paddr == SCT_OFF_CCV)) |=> $stable(compare_capture_ff);
  endproperty
  a_cap_gate: assert property (p_cap_gate) else $error("capture while disabled");

  property p_cap_val;
    (is_in && capture) |=> compare_capture_ff == $past(count_value_ff);
  endproperty
  a_cap_val: assert property (p_cap_val) else $error("captured value wrong");

  property p_stop;
    (reload_value_ff == 16'h0000 && !wr_en) |=> $stable(count_value_ff);
  endproperty
  a_stop: assert property (p_stop) else $error("counter moved at zero reload");

  property p_wrap;
    update_event && !wr_en |=> count_value_ff == 16'h0000;
  endproperty
  a_wrap: assert property (p_wrap) else $error("no wrap at reload");

  property p_count_wr;
    (wr_en && paddr == SCT_OFF_COUNT) |=> count_value_ff == $past(wdata16);
  endproperty
  a_count_wr: assert property (p_count_wr) else $error("count write lost");

  property p_preload;
    (compare_preload_enable && !update_event && $stable(compare_preload_enable))
      |=> $stable(active_compare_ff);
  endproperty
  a_preload: assert property (p_preload) else $error("compare changed early");

  property p_route;
    (input_route_select == SCT_ROUTE_OSC) |-> filtered_chan_input == divided_oscillator_clock;
  endproperty
  a_route: assert property (p_route) else $error("route select wrong");

  property p_apb;
    (psel && !penable) |=> pready ##1 !pready;
  endproperty
  a_apb: assert property (p_apb) else $error("apb answer timing wrong");

  property p_apb_state;
    pready == (apb_state_ff == SCT_APB_ACCESS);
  endproperty
  a_apb_state: assert property (p_apb_state) else $error("apb state and ready disagree");

  property p_direct_cmp;
    (!compare_preload_enable && wr_en && paddr == SCT_OFF_CCV)
      |=> active_compare_ff == $past(wdata16);
  endproperty
  a_direct_cmp: assert property (p_direct_cmp) else $error("direct compare not taken");

  property p_edge_rsvd;
    ({chan_comp_polarity, chan_polarity} == 2'h2) |-> !capture;
  endproperty
  a_edge_rsvd: assert property (p_edge_rsvd) else $error("capture on reserved edge code");

  c_update: cover property (update_event);
  c_capture: cover property (is_in && capture && chan_enable);
  c_out_on: cover property (output_drive_enable && chan_output);
  c_bad_addr: cover property (pslverr);
endmodule
`default_nettype wire

//--- sct_pkg.sv
// Purpose: Constants shared by the single channel timer blocks.
// Assumes: APB byte addresses, 32-bit data, 16-bit registers in the low bits.
// Notes: Overview follows.
// Overview of operation
// - An enabled output channel drives the polarity-adjusted reference with its enable high, a disabled one drives low with enable low.
// - In output mode the polarity bit at 0 makes the output active high and at 1 active low.
// - In input mode the pair {complementary polarity, polarity} selects rising (00), falling (01) or both edges (11), with 10 reserved.
// - In input mode captures are stored only while the channel enable bit is set.
// - The 16-bit counter value is readable and writable by software and resets to zero.
// - The counter tick divides the kernel clock by the divider value plus one, and a new divider value becomes active at the next update event.
// - The written reload value is the value that bounds the counter period.
// - While the reload value is zero the counter stays stopped.
// - A written compare value becomes active at once without preload, or at the next update event with preload.
// - In output mode the active compare value is compared to the counter and the result drives the channel output.
// - In input mode the compare/capture register holds the counter value latched at the latest capture and is readable.
// - The input route field selects the channel pin for codes 00, 01 and 11 and the divided oscillator clock for code 10.
// - The direction field makes the channel an output for 00 or an input from the source chosen by the input route field for 01, with 10 and 11 reserved.
// - The capture event divider is cleared whenever the channel enable bit is zero.

package sct_pkg;
  localparam int unsigned SCT_DW = 16;
  localparam logic [7:0] SCT_OFF_MODE = 8'h18;
  localparam logic [7:0] SCT_OFF_ENPOL = 8'h20;
  localparam logic [7:0] SCT_OFF_COUNT = 8'h24;
  localparam logic [7:0] SCT_OFF_DIV = 8'h28;
  localparam logic [7:0] SCT_OFF_RELOAD = 8'h2c;
  localparam logic [7:0] SCT_OFF_CCV = 8'h34;
  localparam logic [7:0] SCT_OFF_ROUTE = 8'h50;
  localparam logic [15:0] SCT_RST16 = 16'h0000;
  // Enable/polarity field positions
  localparam int unsigned SCT_EN_BIT = 0;
  localparam int unsigned SCT_POL_BIT = 1;
  localparam int unsigned SCT_NPOL_BIT = 3;
  localparam logic [15:0] SCT_ENPOL_MASK = 16'h000b;
  // Mode register field positions
  localparam int unsigned SCT_DIR_LSB = 0;
  localparam int unsigned SCT_EVDIV_LSB = 2;
  localparam int unsigned SCT_PRELOAD_BIT = 4;
  localparam logic [15:0] SCT_MODE_MASK = 16'h001f;
  localparam logic [15:0] SCT_ROUTE_MASK = 16'h0003;
  localparam logic [1:0] SCT_DIR_OUT = 2'h0;
  localparam logic [1:0] SCT_DIR_IN = 2'h1;
  localparam logic [1:0] SCT_ROUTE_OSC = 2'h2;
  localparam logic [1:0] SCT_EDGE_RISE = 2'h0;
  localparam logic [1:0] SCT_EDGE_FALL = 2'h1;
  localparam logic [1:0] SCT_EDGE_BOTH = 2'h3;
  typedef enum logic [1:0] {SCT_APB_IDLE = 2'b00, SCT_APB_ACCESS = 2'b01} sct_apb_t;
endpackage

//--- sct_prescaler.sv
// Purpose: Counter tick divider with an active value reloaded on update.
// Assumes: One clock; tick is a one-cycle enable.
// Notes: Divides by active value plus one.
`timescale 1ns/1ps
`default_nettype none
module sct_prescaler #(
  parameter int unsigned DW = 16
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic [DW-1:0] div_value,
  input wire logic update,
  output logic tick
);
  import sct_pkg::*;
  logic [DW-1:0] active_div_ff;
  logic [DW-1:0] div_cnt_ff;

  // New ratio only at update, so a running period is never cut short
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      active_div_ff <= '0;
    else if (update)
      active_div_ff <= div_value;
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      div_cnt_ff <= '0;
    else if (div_cnt_ff >= active_div_ff)
      div_cnt_ff <= '0;
    else
      div_cnt_ff <= div_cnt_ff + 1'b1;
  end

  assign tick = (div_cnt_ff >= active_div_ff);
endmodule
`default_nettype wire

//--- sct_capture.sv
// Purpose: Edge selection and capture event divider for the channel input.
// Assumes: Input already synchronous to pclk.
// Notes: Divider is held clear while the channel is disabled.
`timescale 1ns/1ps
`default_nettype none
module sct_capture (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic filtered_chan_input,
  input wire logic [1:0] edge_sel,
  input wire logic [1:0] capture_event_divider,
  input wire logic chan_enable,
  output logic capture
);
  import sct_pkg::*;
  logic prev_ff;
  logic [2:0] ev_cnt_ff;
  logic edge_hit;
  logic [2:0] ev_mask;

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      prev_ff <= 1'b0;
    else
      prev_ff <= filtered_chan_input;
  end

  always_comb
  begin
    case (edge_sel)
      SCT_EDGE_RISE: edge_hit = filtered_chan_input & ~prev_ff;
      SCT_EDGE_FALL: edge_hit = ~filtered_chan_input & prev_ff;
      SCT_EDGE_BOTH: edge_hit = filtered_chan_input ^ prev_ff;
      default: edge_hit = 1'b0;
    endcase
    case (capture_event_divider)
      2'h0: ev_mask = 3'h0;
      2'h1: ev_mask = 3'h1;
      2'h2: ev_mask = 3'h3;
      default: ev_mask = 3'h7;
    endcase
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      ev_cnt_ff <= 3'h0;
    else if (!chan_enable)
      ev_cnt_ff <= 3'h0;
    else if (edge_hit)
      ev_cnt_ff <= (ev_cnt_ff & ev_mask) == ev_mask ? 3'h0 : ev_cnt_ff + 3'h1;
  end

  assign capture = chan_enable & edge_hit & ((ev_cnt_ff & ev_mask) == ev_mask);
endmodule
`default_nettype wire

//--- sct_pin_model.sv
// Purpose: External source on the channel pin and the oscillator input.
// Assumes: Both levels are retimed to pclk before the timer sees them.
// Notes: The bench asks for levels; this model presents them one edge later.
`timescale 1ns/1ps
`default_nettype none
module sct_pin_model (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic pin_req,
  input wire logic osc_req,
  output logic chan_pin_in,
  output logic divided_oscillator_clock
);
  // ----------------------------------------
  // Retimed sources
  // ----------------------------------------
  // Registered so the timer never sees a level change off the clock edge
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      chan_pin_in <= 1'b0;
      divided_oscillator_clock <= 1'b0;
    end
    else
    begin
      chan_pin_in <= pin_req;
      divided_oscillator_clock <= osc_req;
    end
  end
endmodule
`default_nettype wire

//--- tb_top.sv
// Purpose: Register and channel checks of the single channel timer.
// Assumes: APB answers after one access cycle; counter held by zero reload.
// Notes: Captures are taken with the counter stopped so values are exact.
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  import sct_pkg::*;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  logic chan_pin_in;
  logic osc;
  logic chan_output;
  logic oe;
  logic pin_req = 1'b0;
  logic osc_req = 1'b0;
  logic [31:0] rd;
  logic err;
  int n_mismatch = 0;
  int samples_checked = 0;
  int cyc = 0;
  int p;
  int h;
  logic [7:0] offs [7] = '{SCT_OFF_MODE, SCT_OFF_ENPOL, SCT_OFF_COUNT,
    SCT_OFF_DIV, SCT_OFF_RELOAD, SCT_OFF_CCV, SCT_OFF_ROUTE};
  logic [15:0] codes [3] = '{16'h0001, 16'h0003, 16'h000b};

  always #10 pclk = ~pclk;

  sct_timer u_sct_timer (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .chan_pin_in(chan_pin_in), .divided_oscillator_clock(osc),
    .chan_output(chan_output), .output_drive_enable(oe));

  sct_pin_model u_sct_pin_model (.pclk(pclk), .presetn(presetn),
    .pin_req(pin_req), .osc_req(osc_req), .chan_pin_in(chan_pin_in),
    .divided_oscillator_clock(osc));

  // ----------------------------------------
  // Shared tasks
  // ----------------------------------------
  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", samples_checked, n_mismatch);
    if (n_mismatch == 0 && samples_checked > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask

  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    samples_checked++;
    if (g !== e)
    begin
      $display("Error %s expected %h seen %h", nm, e, g);
      n_mismatch++;
    end
  endtask

  // Holds the request until pready is sampled high, then idles one cycle
  task automatic apb(input logic w, input logic [7:0] a, input logic [15:0] d);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= {16'h0000, d};
    @(posedge pclk);
    penable <= 1'b1;
    do
    begin
      @(posedge pclk);
    end
    while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask

  task automatic wr(input logic [7:0] a, input logic [15:0] d);
    apb(1'b1, a, d);
  endtask

  task automatic rdc(input string nm, input logic [7:0] a, input logic [15:0] e);
    apb(1'b0, a, 16'h0000);
    chk(nm, {16'h0000, e}, rd);
  endtask

  task automatic pin(input logic v);
    pin_req <= v;
    repeat (4) @(posedge pclk);
  endtask

  task automatic oscl(input logic v);
    osc_req <= v;
    repeat (4) @(posedge pclk);
  endtask

  // Cycles between two rises of the output, and high cycles in that span
  task automatic measure();
    int t0;
    int r;
    logic prv;
    r = 0;
    t0 = 0;
    p = 0;
    h = 0;
    for (int n = 0; n < 80 && r < 2; n++)
    begin
      prv = chan_output;
      @(posedge pclk);
      if (r == 1 && chan_output === 1'b1)
        h++;
      if (prv === 1'b0 && chan_output === 1'b1)
      begin
        r++;
        t0 = (r == 1) ? n : t0;
        p = (r == 2) ? n - t0 : p;
      end
    end
  endtask

  always @(posedge pclk)
  begin
    cyc++;
    if (cyc == 20000)
    begin
      n_mismatch++;
      report_and_stop();
    end
  end

  // ----------------------------------------
  // Test sequence
  // ----------------------------------------
  initial
  begin
    repeat (4) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    foreach (offs[i]) rdc("reset value", offs[i], 16'h0000);
    apb(1'b0, 8'h04, 16'h0000);
    chk("unmapped error", 32'h1, {31'h0, err});
    $display("test reset and map done");
    wr(SCT_OFF_ENPOL, 16'h0003);
    rdc("enpol", SCT_OFF_ENPOL, 16'h0003);
    wr(SCT_OFF_ROUTE, 16'h0003);
    rdc("route", SCT_OFF_ROUTE, 16'h0003);
    wr(SCT_OFF_COUNT, 16'ha5c3);
    repeat (6) @(posedge pclk);
    rdc("stopped count", SCT_OFF_COUNT, 16'ha5c3);
    wr(SCT_OFF_ROUTE, 16'h0000);
    wr(SCT_OFF_COUNT, 16'h0000);
    wr(SCT_OFF_ENPOL, 16'h0000);
    repeat (2) @(posedge pclk);
    chk("disabled out", 32'h0, 32'(chan_output));
    chk("disabled oe", 32'h0, 32'(oe));
    wr(SCT_OFF_CCV, 16'h0001);
    wr(SCT_OFF_ENPOL, 16'h0001);
    repeat (2) @(posedge pclk);
    chk("out high", 32'h1, 32'(chan_output));
    chk("oe on", 32'h1, 32'(oe));
    wr(SCT_OFF_ENPOL, 16'h0003);
    repeat (2) @(posedge pclk);
    chk("out inverted", 32'h0, 32'(chan_output));
    wr(SCT_OFF_ENPOL, 16'h0001);
    wr(SCT_OFF_MODE, 16'h0010);
    wr(SCT_OFF_CCV, 16'h0000);
    repeat (2) @(posedge pclk);
    chk("preload held", 32'h1, 32'(chan_output));
    wr(SCT_OFF_RELOAD, 16'h0003);
    repeat (10) @(posedge pclk);
    chk("preload loaded", 32'h0, 32'(chan_output));
    wr(SCT_OFF_MODE, 16'h0000);
    wr(SCT_OFF_CCV, 16'h0001);
    measure();
    chk("period", 32'd4, p);
    chk("high time", 32'd1, h);
    wr(SCT_OFF_DIV, 16'h0001);
    repeat (12) @(posedge pclk);
    measure();
    chk("divided period", 32'd8, p);
    chk("divided high", 32'd2, h);
    $display("test output channel done");
    wr(SCT_OFF_RELOAD, 16'h0000);
    wr(SCT_OFF_ENPOL, 16'h0000);
    wr(SCT_OFF_MODE, 16'h0001);
    wr(SCT_OFF_CCV, 16'h00ee);
    rdc("ccv preset", SCT_OFF_CCV, 16'h00ee);
    foreach (codes[k])
    begin
      wr(SCT_OFF_ENPOL, codes[k]);
      wr(SCT_OFF_COUNT, 16'h0100 + 16'(k));
      pin(1'b1);
      rdc("rise capture", SCT_OFF_CCV, (k != 1) ? 16'h0100 + 16'(k) : 16'h0100);
      wr(SCT_OFF_COUNT, 16'h0200 + 16'(k));
      pin(1'b0);
      rdc("fall capture", SCT_OFF_CCV, (k != 0) ? 16'h0200 + 16'(k) : 16'h0100);
    end
    wr(SCT_OFF_ENPOL, 16'h0000);
    wr(SCT_OFF_COUNT, 16'h0300);
    pin(1'b1);
    pin(1'b0);
    rdc("capture off", SCT_OFF_CCV, 16'h0202);
    wr(SCT_OFF_ENPOL, 16'h0001);
    wr(SCT_OFF_ROUTE, 16'h0002);
    wr(SCT_OFF_COUNT, 16'h0400);
    pin(1'b1);
    rdc("pin ignored", SCT_OFF_CCV, 16'h0202);
    oscl(1'b1);
    rdc("osc capture", SCT_OFF_CCV, 16'h0400);
    pin(1'b0);
    oscl(1'b0);
    wr(SCT_OFF_ROUTE, 16'h0000);
    wr(SCT_OFF_MODE, 16'h0000);
    rdc("direction locked", SCT_OFF_MODE, 16'h0001);
    wr(SCT_OFF_ENPOL, 16'h0000);
    wr(SCT_OFF_MODE, 16'h0005);
    wr(SCT_OFF_ENPOL, 16'h0001);
    wr(SCT_OFF_COUNT, 16'h0600);
    pin(1'b1);
    pin(1'b0);
    wr(SCT_OFF_ENPOL, 16'h0000);
    wr(SCT_OFF_ENPOL, 16'h0001);
    wr(SCT_OFF_COUNT, 16'h0700);
    pin(1'b1);
    pin(1'b0);
    rdc("divider cleared", SCT_OFF_CCV, 16'h0400);
    pin(1'b1);
    pin(1'b0);
    rdc("second event", SCT_OFF_CCV, 16'h0700);
    // Reserved edge code must never capture
    wr(SCT_OFF_ENPOL, 16'h0009);
    wr(SCT_OFF_COUNT, 16'h0800);
    pin(1'b1);
    pin(1'b0);
    rdc("reserved edge", SCT_OFF_CCV, 16'h0700);
    // One capture in every four events
    wr(SCT_OFF_ENPOL, 16'h0000);
    wr(SCT_OFF_MODE, 16'h0009);
    wr(SCT_OFF_ENPOL, 16'h0001);
    wr(SCT_OFF_COUNT, 16'h0900);
    repeat (3)
    begin
      pin(1'b1);
      pin(1'b0);
    end
    rdc("third event held", SCT_OFF_CCV, 16'h0700);
    wr(SCT_OFF_COUNT, 16'h0a00);
    pin(1'b1);
    rdc("fourth event", SCT_OFF_CCV, 16'h0a00);
    pin(1'b0);
    $display("test input channel done");
    report_and_stop();
  end
endmodule
`default_nettype wire
